// File: rtl/decade_ripple_counter.sv
// module: decade ripple counter, divide-by-two plus divide-by-five
`timescale 1ns/1ps
`default_nettype none

module decade_ripple_counter (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // count inputs, used as ripple clocks
  input  wire logic                     count_in_first,
  input  wire logic                     count_in_second,
  // clear-to-zero and preset-to-nine levels
  input  wire decade_pkg::level_ctrl_t  ctrl,
  // count outputs
  output logic                          count_bit0,
  output logic                          count_bit1,
  output logic                          count_bit2,
  output logic                          count_bit3
);

  // ****************************************************************
  // control decode
  // ****************************************************************
  // the count inputs are sampled on clk, so a ripple edge becomes a
  // one-cycle strobe; pulses must stay at least one clk per level
  logic do_preset;
  logic do_clear;
  logic idle;

  assign do_preset = decade_pkg::preset_active(ctrl);
  assign do_clear  = decade_pkg::clear_active(ctrl);
  assign idle      = ~do_preset & ~do_clear;

  // ****************************************************************
  // falling edge detection on the count inputs
  // ****************************************************************
  logic first_prev_reg;
  logic second_prev_reg;
  logic first_fall;
  logic second_fall;

  // the history keeps tracking during clear and preset, so releasing
  // them never creates a stray count edge
  // history resets low to match the idle level of the count pins; an
  // input held high through reset counts only on its later fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      first_prev_reg <= 1'b0;
    end else begin
      first_prev_reg <= count_in_first;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      second_prev_reg <= 1'b0;
    end else begin
      second_prev_reg <= count_in_second;
    end
  end

  assign first_fall  = first_prev_reg & ~count_in_first;
  assign second_fall = second_prev_reg & ~count_in_second;

  // ****************************************************************
  // divide-by-two stage
  // ****************************************************************
  logic bit0_reg;
  logic bit0_next;

  always_comb begin
    bit0_next = bit0_reg;
    if (do_preset) begin
      bit0_next = decade_pkg::NINE_VALUE[decade_pkg::BIT0_POS];
    end else if (do_clear) begin
      bit0_next = decade_pkg::ZERO_VALUE[decade_pkg::BIT0_POS];
    end else if (first_fall) begin
      bit0_next = ~bit0_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit0_reg <= decade_pkg::ZERO_VALUE[decade_pkg::BIT0_POS];
    end else begin
      bit0_reg <= bit0_next;
    end
  end

  // ****************************************************************
  // divide-by-five section
  // ****************************************************************
  logic [decade_pkg::QUINARY_W-1:0] quinary_value;

  quinary_stage u_quinary (
    .clk       (clk),
    .arst_n    (arst_n),
    .advance   (second_fall),
    .load_zero (do_clear),
    .load_nine (do_preset),
    .value     (quinary_value)
  );

  // ****************************************************************
  // outputs
  // ****************************************************************
  // bit three carries the divide-by-five result; the wiring for decade
  // or bi-quinary use is left to the surrounding logic
  assign count_bit0 = bit0_reg;
  assign count_bit1 = quinary_value[0];
  assign count_bit2 = quinary_value[1];
  assign count_bit3 = quinary_value[2];

  // ****************************************************************
  // checks
  // ****************************************************************
  // checks watch the pins, not the registers behind them, so a slip in
  // the output mapping shows up here as well
  logic [decade_pkg::COUNT_W-1:0]   count_now;
  logic [decade_pkg::QUINARY_W-1:0] upper_now;

  assign count_now = {count_bit3, count_bit2, count_bit1, count_bit0};
  assign upper_now = {count_bit3, count_bit2, count_bit1};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_CLEAR_ZERO: assert property (
    ctrl.clear_zero_a && ctrl.clear_zero_b
      && !(ctrl.preset_nine_a && ctrl.preset_nine_b)
      |=> count_now == decade_pkg::ZERO_VALUE)
    else $error("clear pair did not force zero");

  AST_PRESET_NINE: assert property (
    ctrl.preset_nine_a && ctrl.preset_nine_b
      |=> count_now == decade_pkg::NINE_VALUE)
    else $error("preset pair did not force nine");

  AST_PRESET_HOLD: assert property (
    (ctrl.preset_nine_a && ctrl.preset_nine_b) [*3]
      |=> count_now == decade_pkg::NINE_VALUE)
    else $error("nine not held while preset stays asserted");

  AST_BIT0_TOGGLE: assert property (
    $fell(count_in_first) && idle |=> count_bit0 != $past(count_bit0))
    else $error("bit zero did not toggle on a falling first input");

  AST_BIT0_HOLD: assert property (
    !$fell(count_in_first) && idle |=> $stable(count_bit0))
    else $error("bit zero moved without a falling first input");

  AST_QUINARY_QUIET: assert property (
    !$fell(count_in_second) && idle
      |=> $stable({count_bit3, count_bit2, count_bit1}))
    else $error("divide-by-five bits moved without a count edge");

  AST_BCD_WRAP: assert property (
    (count_now == decade_pkg::NINE_VALUE && $fell(count_in_first)
      && idle && count_in_second == count_bit0)
      ##1 (count_in_second == count_bit0 && idle)
      |=> count_now == decade_pkg::ZERO_VALUE)
    else $error("decade wiring did not wrap nine to zero");

  // the loop must hold on both edges: a section wrap with the first
  // input already low would otherwise pass for a feed
  AST_BIQUINARY_FEED: assert property (
    (count_in_first == count_bit3 && idle && $fell(count_bit3)
      && $past(count_in_first) == $past(count_bit3))
      |=> count_bit0 != $past(count_bit0))
    else $error("bit three falling did not clock bit zero");

  // written from the pairs themselves, so a slip in the shared decode
  // functions cannot hide behind idle
  AST_PAIRS_COUNT: assert property (
    !(ctrl.clear_zero_a && ctrl.clear_zero_b)
      && !(ctrl.preset_nine_a && ctrl.preset_nine_b)
      && $fell(count_in_first)
      |=> count_bit0 != $past(count_bit0))
    else $error("half-asserted pairs stopped the count");

  AST_SECOND_STEP: assert property (
    $fell(count_in_second) && idle
      |=> upper_now == (($past(upper_now) == decade_pkg::QUINARY_LAST) ?
                        decade_pkg::QUINARY_ZERO :
                        $past(upper_now) + decade_pkg::QUINARY_ONE))
    else $error("divide-by-five bits did not step on a falling input");

  AST_FIRST_ONLY_BIT0: assert property (
    $fell(count_in_first) && !$fell(count_in_second) && idle
      |=> $stable(upper_now))
    else $error("first count input disturbed the divide-by-five bits");

  AST_IDLE_STEADY: assert property (
    idle && !$fell(count_in_first) && !$fell(count_in_second)
      |=> $stable(count_now))
    else $error("count moved with no falling count input");

  COV_CLEAR: cover property (
    do_clear ##1 count_now == decade_pkg::ZERO_VALUE);

  COV_PRESET_OVER_CLEAR: cover property (
    do_preset && ctrl.clear_zero_a && ctrl.clear_zero_b);

  COV_BCD_WRAP: cover property (
    count_now == decade_pkg::NINE_VALUE && idle
      ##[1:4] count_now == decade_pkg::ZERO_VALUE);

  COV_BIQUINARY: cover property (
    idle && count_in_first == count_bit3 && $fell(count_bit3));

endmodule

`default_nettype wire

// File: rtl/decade_pkg.sv
// package: constants, types and decodes shared by the decade counter files
`default_nettype none

package decade_pkg;

  // ****************************************************************
  // widths and fixed values
  // ****************************************************************
  localparam int unsigned COUNT_W   = 4;
  localparam int unsigned QUINARY_W = 3;

  localparam logic [COUNT_W-1:0]   ZERO_VALUE   = 4'h0;
  // nine is high, low, low, high from the top bit down
  localparam logic [COUNT_W-1:0]   NINE_VALUE   = 4'h9;
  localparam logic [QUINARY_W-1:0] QUINARY_ZERO = 3'h0;
  localparam logic [QUINARY_W-1:0] QUINARY_ONE  = 3'h1;
  localparam logic [QUINARY_W-1:0] QUINARY_LAST = 3'h4;

  // field positions in the four-bit count
  localparam int unsigned BIT0_POS    = 0;
  localparam int unsigned QUINARY_LSB = 1;
  localparam int unsigned QUINARY_MSB = 3;

  // ****************************************************************
  // level controls
  // ****************************************************************
  typedef struct packed {
    logic clear_zero_a;
    logic clear_zero_b;
    logic preset_nine_a;
    logic preset_nine_b;
  } level_ctrl_t;

  function automatic logic preset_active(input level_ctrl_t c);
    preset_active = c.preset_nine_a & c.preset_nine_b;
  endfunction

  // preset outranks clear, so clear only counts with preset released
  function automatic logic clear_active(input level_ctrl_t c);
    clear_active = c.clear_zero_a & c.clear_zero_b & ~preset_active(c);
  endfunction

  function automatic logic [QUINARY_W-1:0] quinary_next(
    input logic [QUINARY_W-1:0] v
  );
    quinary_next = (v >= QUINARY_LAST) ? QUINARY_ZERO : v + QUINARY_ONE;
  endfunction

endpackage

`default_nettype wire

// File: rtl/quinary_stage.sv
// module: three-flop divide-by-five section with zero and nine loads
`timescale 1ns/1ps
`default_nettype none

module quinary_stage (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             arst_n,
  // control
  input  wire logic                             advance,
  input  wire logic                             load_zero,
  input  wire logic                             load_nine,
  // state
  output logic [decade_pkg::QUINARY_W-1:0]      value
);

  logic [decade_pkg::QUINARY_W-1:0] value_reg;
  logic [decade_pkg::QUINARY_W-1:0] value_next;

  // ****************************************************************
  // counting
  // ****************************************************************
  always_comb begin
    value_next = value_reg;
    if (load_nine) begin
      value_next = decade_pkg::NINE_VALUE[decade_pkg::QUINARY_MSB:
                                          decade_pkg::QUINARY_LSB];
    end else if (load_zero) begin
      value_next = decade_pkg::QUINARY_ZERO;
    end else if (advance) begin
      value_next = decade_pkg::quinary_next(value_reg);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= decade_pkg::QUINARY_ZERO;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_QUINARY_STEP: assert property (
    advance && !load_zero && !load_nine |=>
      value == (($past(value) == decade_pkg::QUINARY_LAST) ?
                decade_pkg::QUINARY_ZERO : $past(value) + 3'h1))
    else $error("divide-by-five section did not step");

  AST_QUINARY_RANGE: assert property (
    value <= decade_pkg::QUINARY_LAST)
    else $error("divide-by-five section left its five states");

  AST_QUINARY_HOLD: assert property (
    !advance && !load_zero && !load_nine |=> $stable(value))
    else $error("divide-by-five section moved without a count edge");

  COV_QUINARY_WRAP: cover property (
    value == decade_pkg::QUINARY_LAST && advance && !load_zero
      && !load_nine ##1 value == decade_pkg::QUINARY_ZERO);

endmodule

`default_nettype wire

// File: sim/count_source.sv
// partner: surrounding logic that feeds the two count inputs
`timescale 1ns/1ps
`default_nettype none

module count_source (
  // wiring choice and pulse sources
  input  wire logic [1:0] wiring,
  input  wire logic       pulse_a,
  input  wire logic       pulse_b,
  // feedback from the counter
  input  wire logic       count_bit0,
  input  wire logic       count_bit3,
  // count inputs of the counter
  output logic            count_in_first,
  output logic            count_in_second
);
  // 2'h2 closes the bi-quinary loop: bit three clocks the toggle stage
  assign count_in_first  = (wiring == 2'h2) ? count_bit3 : pulse_a;
  // 2'h1 closes the decade loop: bit zero clocks the quinary section
  assign count_in_second = (wiring == 2'h1) ? count_bit0 : pulse_b;
endmodule

`default_nettype wire

// File: sim/testbench.sv
// testbench: scenarios for the decade ripple counter
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                    clk;
  logic                    arst_n;
  logic [1:0]              wiring;
  logic                    pulse_a;
  logic                    pulse_b;
  decade_pkg::level_ctrl_t ctrl;
  logic                    count_in_first;
  logic                    count_in_second;
  logic                    count_bit0;
  logic                    count_bit1;
  logic                    count_bit2;
  logic                    count_bit3;
  logic [3:0]              seen;
  int                      bad_count;
  int                      compares;

  assign seen = {count_bit3, count_bit2, count_bit1, count_bit0};

  decade_ripple_counter i_decade_ripple_counter (
    .clk            (clk),
    .arst_n         (arst_n),
    .count_in_first (count_in_first),
    .count_in_second(count_in_second),
    .ctrl           (ctrl),
    .count_bit0     (count_bit0),
    .count_bit1     (count_bit1),
    .count_bit2     (count_bit2),
    .count_bit3     (count_bit3)
  );

  count_source i_count_source (
    .wiring         (wiring),
    .pulse_a        (pulse_a),
    .pulse_b        (pulse_b),
    .count_bit0     (count_bit0),
    .count_bit3     (count_bit3),
    .count_in_first (count_in_first),
    .count_in_second(count_in_second)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // levels last two clocks; five more let a two-link ripple settle
  task automatic pulse(input bit on_b);
    @(negedge clk);
    if (on_b)
      pulse_b = 1'b1;
    else
      pulse_a = 1'b1;
    repeat (2) @(negedge clk);
    pulse_a = 1'b0;
    pulse_b = 1'b0;
    repeat (5) @(negedge clk);
  endtask

  task automatic set_ctrl(input logic [3:0] lv, input logic [3:0] exp,
                          input string what);
    @(negedge clk);
    ctrl = decade_pkg::level_ctrl_t'(lv);
    repeat (2) @(negedge clk);
    check(what, exp);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_toggle();
    @(negedge clk);
    pulse_a = 1'b1;
    repeat (3) @(negedge clk);
    check("rise ignored", 4'h0);
    pulse_a = 1'b0;
    repeat (3) @(negedge clk);
    check("toggle one", 4'h1);
    pulse(1'b0);
    check("toggle two", 4'h0);
  endtask

  task automatic sc_quinary();
    for (int k = 1; k <= 5; k++) begin
      pulse(1'b1);
      check("quinary step", 4'((k % 5) * 2));
    end
  endtask

  task automatic sc_levels();
    set_ctrl(4'hF, 4'h9, "preset over clear");
    set_ctrl(4'hE, 4'h0, "clear preset b low");
    set_ctrl(4'h3, 4'h9, "preset alone");
    set_ctrl(4'hD, 4'h0, "clear preset a low");
    pulse(1'b0);
    check("count held in clear", 4'h0);
    set_ctrl(4'h0, 4'h0, "clear released");
    pulse(1'b0);
    check("count resumes", 4'h1);
    set_ctrl(4'hA, 4'h1, "half pairs hold");
    pulse(1'b0);
    check("count with half pairs", 4'h0);
    set_ctrl(4'h5, 4'h0, "other half pairs");
    pulse(1'b0);
    check("count other half pairs", 4'h1);
    arst_n = 1'b0;
    ctrl = '0;
    repeat (2) @(negedge clk);
    check("mid-run reset", 4'h0);
    arst_n = 1'b1;
  endtask

  task automatic sc_decade();
    wiring = 2'h1;
    for (int k = 1; k <= 10; k++) begin
      pulse(1'b0);
      check("decade step", 4'(k % 10));
    end
  endtask

  task automatic sc_biquinary();
    wiring = 2'h2;
    for (int k = 1; k <= 10; k++) begin
      pulse(1'b1);
      check("biquinary step", 4'((k % 5) * 2 + (k / 5) % 2));
    end
  endtask

  initial begin
    arst_n = 1'b0;
    wiring = 2'h0;
    pulse_a = 1'b0;
    pulse_b = 1'b0;
    ctrl = '0;
    bad_count = 0;
    compares = 0;
    repeat (12) @(negedge clk);
    check("reset value", 4'h0);
    arst_n = 1'b1;
    sc_toggle();
    sc_quinary();
    sc_levels();
    sc_decade();
    sc_biquinary();
    final_report();
  end

  // the scenarios need about 300 clocks; this allows over ten times that
  initial begin
    #20000;
    bad_count++;
    final_report();
  end
endmodule

`default_nettype wire
